/* verilog/cais_pkg.sv */
// Purpose: Shared constants and types for the channel adapter initial selection block
// Assumes: One 25 MHz clock; channel pins arrive asynchronous and are synchronised
// Notes: Status bits follow the usual channel status byte layout
//
// What this block does
// - No cycle stealing; every data burst passes through program-visible registers.
// - At most four bytes move per burst; program arms before and acknowledges after.
// - Native or emulated mode is chosen by the program's asynchronous control bit.
// - Native mode answers one address per interface and is forced during boot load.
// - Emulated mode answers a range of addresses, one per communication line.
// - With interface enabled, bus-out address is compared during initial selection.
// - Native address comes from an 8-bit jumper strap, any value 0 to 255.
// - Dual interface: each interface has its own native address strap.
// - Lowest emulated address is 0 or a multiple of 16, up to 240.
// - Highest emulated address exceeds lowest and ends in binary 11.
// - Both interfaces share one emulated address range.
// - Hard stop: addresses ignored, select passed on, enabled indicator stays lit.
// - A command byte with good bus-out parity is accepted, except No-op, emulated Test I/O, or under a pending reject or stacked native status.
// - Initial status is zero for good parity, no No-op, and no pending reject or stacked native status.
// - After initial status of an accepted command, raise initial level 3 request.
// - Program-rejected commands present channel end, unit finished and error status.
// - Address and command bytes of initial selection are held for program reads.

package cais_pkg;

    // ==========================================================
    // Command and status encodings
    localparam logic [7:0] CMD_TEST_IO = 8'h00;
    localparam logic [7:0] CMD_NOOP = 8'h03;
    localparam logic [7:0] ST_ZERO = 8'h00;
    localparam logic [7:0] ST_CHAN_END = 8'h08;
    localparam logic [7:0] ST_UNIT_FINISHED = 8'h04;
    localparam logic [7:0] ST_ERROR = 8'h02;

    // ==========================================================
    // Address range and burst size constraints
    localparam int EMU_LOW_ZERO_BITS = 4;
    localparam int EMU_HIGH_ONE_BITS = 2;
    localparam int MAX_BURST_BYTES = 4;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic operational;
        logic select;
        logic address;
        logic command;
        logic service;
    } cais_tags_out_t;

    typedef struct packed {
        logic operational;
        logic select_pass;
        logic address;
        logic status;
        logic service;
        logic request;
    } cais_tags_in_t;

    typedef struct packed {
        logic [7:0] dev_addr;
        logic [7:0] command;
    } cais_isel_t;

    typedef struct packed {
        logic selection;
        logic bus_out_check;
        logic stack_cleared;
        logic emulated_hit;
    } cais_cause_t;

endpackage : cais_pkg

/* verilog/cais_sync.sv */
// Purpose: Two-stage synchroniser for asynchronous channel pins
// Assumes: Inputs are levels held long enough to be sampled
// Notes: First stage is read only by the second stage
`timescale 1ns/10ps
`default_nettype none

module cais_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule : cais_sync

`default_nettype wire

/* verilog/cais_match.sv */
// Purpose: Address compare for one channel interface
// Assumes: Strap values are stable after capture
// Notes: An invalid emulated range never matches
`timescale 1ns/10ps
`default_nettype none

module cais_match (
    input wire logic [7:0] dev_addr,
    input wire logic [7:0] native_addr,
    input wire logic [7:0] emu_low,
    input wire logic [7:0] emu_high,
    input wire logic emulated_mode,
    output logic hit_native,
    output logic hit_emulated
);

    logic range_ok;

    // Low on a 16 boundary, high one below a multiple of 4, high above low
    assign range_ok = (emu_low[cais_pkg::EMU_LOW_ZERO_BITS-1:0] == '0)
        && (&emu_high[cais_pkg::EMU_HIGH_ONE_BITS-1:0])
        && (emu_high > emu_low);
    assign hit_native = !emulated_mode && (dev_addr == native_addr);
    assign hit_emulated = emulated_mode && range_ok
        && (dev_addr >= emu_low) && (dev_addr <= emu_high);

endmodule : cais_match

`default_nettype wire

/* verilog/cais_adapter.sv */
// Purpose: Initial selection front end of a host channel adapter
// Assumes: Channel pins asynchronous; program-side ports on clk
// Notes: Data bursts are armed and drained by the program, never by cycle stealing
`timescale 1ns/10ps
`default_nettype none

module cais_adapter #(
    parameter int MAX_BURST = cais_pkg::MAX_BURST_BYTES
) (
    input wire logic clk,
    input wire logic nrst,
    // Channel side
    input wire cais_pkg::cais_tags_out_t tags_out,
    input wire logic [7:0] bus_out,
    input wire logic bus_out_par,
    output cais_pkg::cais_tags_in_t tags_in,
    output logic [7:0] bus_in,
    output logic bus_in_par,
    // Straps
    input wire logic [7:0] native_addr_a,
    input wire logic [7:0] native_addr_b,
    input wire logic [7:0] emu_low,
    input wire logic [7:0] emu_high,
    input wire logic dual_intf,
    input wire logic intf_b_active,
    // Controls
    input wire logic intf_enable,
    input wire logic hard_stop,
    input wire logic boot_load,
    input wire logic emulated_subchannel_mode,
    output logic intf_enabled_lamp,
    output logic native_subchannel_mode,
    // Program side
    input wire logic prog_init_ack,
    input wire logic prog_reject,
    input wire logic prog_stack_status,
    input wire logic [7:0] prog_native_status,
    input wire logic prog_burst_arm,
    input wire logic [2:0] prog_burst_count,
    input wire logic [31:0] prog_out_data,
    input wire logic prog_data_ack,
    output cais_pkg::cais_isel_t isel_reg,
    output cais_pkg::cais_cause_t init_cause,
    output logic init_l3_req,
    output logic data_l3_req,
    output logic [31:0] prog_in_data,
    output logic [2:0] burst_done_count
);

    // ==========================================================
    // Parameter check
    if (MAX_BURST < 1 || MAX_BURST > cais_pkg::MAX_BURST_BYTES) begin : g_bad_burst
        $error("MAX_BURST must be 1 to 4");
    end

    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_CMD_END, S_STATUS, S_STATUS_END, S_DATA, S_DATA_END, S_PASS
    } cais_state_t;

    // ==========================================================
    // Synchronised channel inputs
    cais_pkg::cais_tags_out_t tags_s;
    logic [7:0] bus_s;
    logic par_s;

    cais_sync #(.WIDTH(14)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .d({tags_out, bus_out, bus_out_par}),
        .q({tags_s, bus_s, par_s})
    );

    // ==========================================================
    // Strap capture after reset release
    logic strap_done_r;
    logic [7:0] nat_a_r;
    logic [7:0] nat_b_r;
    logic [7:0] emu_low_r;
    logic [7:0] emu_high_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_done_r <= 1'b0;
            nat_a_r <= 8'h00;
            nat_b_r <= 8'h00;
            emu_low_r <= 8'h00;
            emu_high_r <= 8'h00;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            nat_a_r <= native_addr_a;
            nat_b_r <= native_addr_b;
            emu_low_r <= emu_low;
            emu_high_r <= emu_high;
        end
    end

    // ==========================================================
    // Address match, one per interface
    logic emu_mode;
    logic hit_nat_a;
    logic hit_emu_a;
    logic hit_nat_b;
    logic hit_emu_b;
    logic use_b;
    logic hit_nat;
    logic hit_emu;
    logic enabled;

    assign emu_mode = emulated_subchannel_mode && !boot_load;
    assign native_subchannel_mode = !emu_mode;
    assign use_b = dual_intf && intf_b_active;

    cais_match u_match_a (
        .dev_addr(bus_s),
        .native_addr(nat_a_r),
        .emu_low(emu_low_r),
        .emu_high(emu_high_r),
        .emulated_mode(emu_mode),
        .hit_native(hit_nat_a),
        .hit_emulated(hit_emu_a)
    );

    // Same emulated straps feed both interfaces
    cais_match u_match_b (
        .dev_addr(bus_s),
        .native_addr(nat_b_r),
        .emu_low(emu_low_r),
        .emu_high(emu_high_r),
        .emulated_mode(emu_mode),
        .hit_native(hit_nat_b),
        .hit_emulated(hit_emu_b)
    );

    assign hit_nat = use_b ? hit_nat_b : hit_nat_a;
    assign hit_emu = use_b ? hit_emu_b : hit_emu_a;
    assign enabled = intf_enable && !hard_stop && strap_done_r;
    assign intf_enabled_lamp = intf_enable;

    // ==========================================================
    // Selection sequencer
    cais_state_t state_r;
    logic par_ok;
    logic cmd_taken;
    logic accepted_r;
    logic emu_hit_r;
    logic stacked_r;
    logic reject_pend_r;
    logic [7:0] status_nxt;
    logic [2:0] burst_len_r;
    logic armed_r;
    logic [31:0] out_buf_r;

    assign par_ok = ^{bus_s, par_s};
    assign cmd_taken = (state_r == S_ADDR) && tags_s.command;

    // Initial status choice
    always_comb begin
        status_nxt = cais_pkg::ST_ZERO;
        if (!par_ok) begin
            status_nxt = cais_pkg::ST_ERROR;
        end else if (reject_pend_r) begin
            status_nxt = cais_pkg::ST_CHAN_END | cais_pkg::ST_UNIT_FINISHED
                | cais_pkg::ST_ERROR;
        end else if (stacked_r && !emu_hit_r) begin
            status_nxt = prog_native_status;
        end else if (bus_s == cais_pkg::CMD_NOOP) begin
            status_nxt = cais_pkg::ST_CHAN_END | cais_pkg::ST_UNIT_FINISHED;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= S_IDLE;
        end else if (!tags_s.operational && state_r != S_IDLE) begin
            state_r <= S_IDLE;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (tags_s.select && tags_s.address && enabled && (hit_nat || hit_emu)) begin
                        state_r <= S_ADDR;
                    end else if (tags_s.select) begin
                        state_r <= S_PASS;
                    end
                end
                S_PASS: begin
                    if (!tags_s.select) begin
                        state_r <= S_IDLE;
                    end
                end
                S_ADDR: begin
                    if (tags_s.command) begin
                        state_r <= S_CMD_END;
                    end
                end
                S_CMD_END: begin
                    if (!tags_s.command) begin
                        state_r <= S_STATUS;
                    end
                end
                S_STATUS: begin
                    if (tags_s.service) begin
                        state_r <= S_STATUS_END;
                    end
                end
                S_STATUS_END: begin
                    if (!tags_s.service) begin
                        state_r <= (accepted_r && armed_r) ? S_DATA : S_IDLE;
                    end
                end
                S_DATA: begin
                    if (tags_s.service) begin
                        state_r <= S_DATA_END;
                    end
                end
                S_DATA_END: begin
                    if (!tags_s.service) begin
                        state_r <= (burst_done_count + 3'd1 >= burst_len_r) ? S_IDLE : S_DATA;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // Address and command capture, status byte, acceptance
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            isel_reg <= '0;
            emu_hit_r <= 1'b0;
            accepted_r <= 1'b0;
            bus_in <= 8'h00;
        end else if (state_r == S_IDLE && tags_s.select && tags_s.address && enabled
                && (hit_nat || hit_emu)) begin
            isel_reg.dev_addr <= bus_s;
            emu_hit_r <= hit_emu;
            bus_in <= bus_s;
        end else if (cmd_taken) begin
            isel_reg.command <= bus_s;
            bus_in <= status_nxt;
            accepted_r <= par_ok && !reject_pend_r && !(stacked_r && !emu_hit_r)
                && (bus_s != cais_pkg::CMD_NOOP)
                && !(emu_hit_r && bus_s == cais_pkg::CMD_TEST_IO);
        end else if (state_r == S_DATA) begin
            bus_in <= out_buf_r[8*burst_done_count +: 8];
        end
    end

    assign bus_in_par = ~^bus_in;

    // Stacked native status and pending reject
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stacked_r <= 1'b0;
            reject_pend_r <= 1'b0;
        end else begin
            if (prog_stack_status) begin
                stacked_r <= 1'b1;
            end else if (cmd_taken && !emu_hit_r) begin
                stacked_r <= 1'b0;
            end
            if (prog_reject) begin
                reject_pend_r <= 1'b1;
            end else if (cmd_taken) begin
                reject_pend_r <= 1'b0;
            end
        end
    end

    // Initial selection level 3 request; a new event wins over the acknowledge
    logic init_set;
    assign init_set = (state_r == S_STATUS_END) && !tags_s.service && accepted_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            init_l3_req <= 1'b0;
            init_cause <= '0;
        end else if (init_set || (cmd_taken && !par_ok)) begin
            init_l3_req <= 1'b1;
            init_cause.selection <= init_set;
            init_cause.bus_out_check <= !par_ok;
            init_cause.stack_cleared <= stacked_r && !emu_hit_r;
            init_cause.emulated_hit <= emu_hit_r;
        end else if (prog_init_ack) begin
            init_l3_req <= 1'b0;
            init_cause <= '0;
        end
    end

    // ==========================================================
    // Program-driven data burst
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            armed_r <= 1'b0;
            burst_len_r <= 3'd0;
            out_buf_r <= 32'h0000_0000;
        end else if (prog_burst_arm && !armed_r) begin
            armed_r <= (prog_burst_count != 3'd0);
            burst_len_r <= (prog_burst_count > 3'(MAX_BURST)) ? 3'(MAX_BURST) : prog_burst_count;
            out_buf_r <= prog_out_data;
        end else if (state_r == S_DATA_END && !tags_s.service
                && burst_done_count + 3'd1 >= burst_len_r) begin
            armed_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            burst_done_count <= 3'd0;
            prog_in_data <= 32'h0000_0000;
        end else if (prog_burst_arm && !armed_r) begin
            burst_done_count <= 3'd0;
        end else if (state_r == S_DATA && tags_s.service) begin
            prog_in_data[8*burst_done_count +: 8] <= bus_s;
        end else if (state_r == S_DATA_END && !tags_s.service) begin
            burst_done_count <= burst_done_count + 3'd1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_l3_req <= 1'b0;
        end else if (state_r == S_DATA_END && !tags_s.service
                && burst_done_count + 3'd1 >= burst_len_r) begin
            data_l3_req <= 1'b1;
        end else if (prog_data_ack) begin
            data_l3_req <= 1'b0;
        end
    end

    // ==========================================================
    // Inbound tags
    always_comb begin
        tags_in = '0;
        tags_in.operational = (state_r != S_IDLE) && (state_r != S_PASS);
        tags_in.select_pass = (state_r == S_PASS);
        tags_in.address = (state_r == S_ADDR);
        tags_in.status = (state_r == S_STATUS);
        tags_in.service = (state_r == S_DATA);
        tags_in.request = reject_pend_r || stacked_r;
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence addr_phase_s;
        state_r == S_ADDR && tags_s.command;
    endsequence

    no_trap_stop_a: assert property (hard_stop |=> state_r != S_ADDR || $past(state_r) == S_ADDR)
        else $error("address trapped during hard stop");
    lamp_stop_a: assert property (intf_enable |-> intf_enabled_lamp)
        else $error("enabled lamp dropped");
    boot_native_a: assert property (boot_load |-> native_subchannel_mode)
        else $error("emulated mode during boot load");
    isel_cap_a: assert property (addr_phase_s |=> isel_reg.command == $past(bus_s))
        else $error("command byte not captured");
    zero_stat_a: assert property (addr_phase_s ##0 (par_ok && !reject_pend_r && !stacked_r
        && bus_s != cais_pkg::CMD_NOOP && !emu_hit_r) |=> bus_in == 8'h00)
        else $error("initial status not zero");
    reject_stat_a: assert property (addr_phase_s ##0 (par_ok && reject_pend_r) |=> bus_in == 8'h0E)
        else $error("reject status wrong");
    init_irq_a: assert property (init_set |=> init_l3_req && init_cause.selection)
        else $error("initial request not raised");
    burst_max_a: assert property (burst_done_count <= 3'(MAX_BURST))
        else $error("burst exceeded four bytes");
    burst_stop_a: assert property ($rose(data_l3_req) |-> !armed_r ##1 state_r != S_DATA)
        else $error("burst continued without program");
    sequence emu_sel_s;
        state_r == S_IDLE && tags_s.select && tags_s.address && enabled && hit_emu;
    endsequence

    emu_hit_a: assert property (emu_sel_s |=> state_r == S_ADDR && emu_hit_r)
        else $error("emulated address not trapped");

endmodule : cais_adapter

`default_nettype wire

/* test/cais_chan_model.sv */
// Purpose: Behavioural host channel that runs initial selection sequences
// Assumes: The adapter answers each tag within a few cycles
// Notes: Released bus-out shows the inverse of its last byte
`timescale 1ns/10ps
`default_nettype none

module cais_chan_model (
    input wire logic clk,
    input wire logic nrst,
    output var cais_pkg::cais_tags_out_t tags_out,
    output var logic [7:0] bus_out,
    output var logic bus_out_par,
    input wire cais_pkg::cais_tags_in_t tags_in,
    input wire logic [7:0] bus_in
);
    // ==========================================================
    // Helpers
    task automatic step;
        @(posedge clk);
        #2;
    endtask : step

    task automatic put(input logic [7:0] v, input logic bad);
        bus_out = v;
        bus_out_par = (~^v) ^ bad;
    endtask : put

    task automatic wait_for(input int which, input logic lvl);
        int n;
        n = 0;
        while (((which == 0) ? tags_in.address : tags_in.status) !== lvl && n < 20) begin
            step();
            n++;
        end
    endtask : wait_for

    initial begin
        tags_out = '0;
        put(8'h00, 1'b0);
        @(posedge nrst);
        step();
        tags_out.operational = 1'b1;
    end

    // ==========================================================
    // Initial selection: address, command, then take status
    task automatic sel(input logic [7:0] a, input logic [7:0] c, input logic bad,
                       output logic hit, output logic [7:0] echo, output logic [7:0] st);
        int n;
        hit = 1'b0;
        echo = 8'hEE;
        st = 8'hEE;
        step();
        tags_out.select = 1'b1;
        tags_out.address = 1'b1;
        put(a, 1'b0);
        n = 0;
        while (tags_in.address !== 1'b1 && tags_in.select_pass !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        if (tags_in.address === 1'b1) begin
            hit = 1'b1;
            echo = bus_in;
            tags_out.address = 1'b0;
            tags_out.command = 1'b1;
            put(c, bad);
            wait_for(0, 1'b0);
            step();
            tags_out.command = 1'b0;
            put(~bus_out, 1'b0);
            wait_for(1, 1'b1);
            st = bus_in;
            tags_out.service = 1'b1;
            wait_for(1, 1'b0);
            step();
            tags_out.service = 1'b0;
        end
        tags_out.select = 1'b0;
        tags_out.address = 1'b0;
        put(~bus_out, 1'b0);
    endtask : sel
endmodule : cais_chan_model
`default_nettype wire

/* test/tb_channel_adapter_initial_selection.sv */
// Purpose: Self-checking bench for the initial selection front end
// Assumes: Straps are set before reset and captured after its release
// Notes: Data burst inputs stay idle; only selection behaviour is run
`timescale 1ns/10ps
`default_nettype none

module tb_channel_adapter_initial_selection;
    logic clk;
    logic nrst;
    cais_pkg::cais_tags_out_t tags_out;
    cais_pkg::cais_tags_in_t tags_in;
    logic [7:0] bus_out, bus_in, nat_a, nat_b, emu_lo, emu_hi, prog_native_status;
    logic bus_out_par, bus_in_par, dual_intf, intf_b_active, intf_enable, hard_stop, boot_load;
    logic emulated_subchannel_mode, lamp, native_subchannel_mode;
    logic prog_init_ack, prog_reject, prog_stack_status, init_l3_req, data_l3_req;
    cais_pkg::cais_isel_t isel_reg;
    cais_pkg::cais_cause_t init_cause;
    logic [31:0] prog_in_data;
    logic [2:0] burst_done_count;
    int failures, samples_checked, cycles;
    logic [7:0] cmds [4] = '{8'h01, 8'h02, 8'h80, 8'hFF};

    cais_adapter dut_u (.clk(clk), .nrst(nrst), .tags_out(tags_out), .bus_out(bus_out),
        .bus_out_par(bus_out_par), .tags_in(tags_in), .bus_in(bus_in), .bus_in_par(bus_in_par),
        .native_addr_a(nat_a), .native_addr_b(nat_b), .emu_low(emu_lo), .emu_high(emu_hi),
        .dual_intf(dual_intf), .intf_b_active(intf_b_active), .intf_enable(intf_enable),
        .hard_stop(hard_stop), .boot_load(boot_load),
        .emulated_subchannel_mode(emulated_subchannel_mode), .intf_enabled_lamp(lamp),
        .native_subchannel_mode(native_subchannel_mode), .prog_init_ack(prog_init_ack),
        .prog_reject(prog_reject), .prog_stack_status(prog_stack_status),
        .prog_native_status(prog_native_status), .prog_burst_arm(1'b0),
        .prog_burst_count(3'h0), .prog_out_data(32'h0), .prog_data_ack(1'b0),
        .isel_reg(isel_reg), .init_cause(init_cause), .init_l3_req(init_l3_req),
        .data_l3_req(data_l3_req), .prog_in_data(prog_in_data),
        .burst_done_count(burst_done_count));

    cais_chan_model chan_u (.clk(clk), .nrst(nrst), .tags_out(tags_out), .bus_out(bus_out),
        .bus_out_par(bus_out_par), .tags_in(tags_in), .bus_in(bus_in));

    // ==========================================================
    // Clock, timeout and reporting
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            finish_test();
        end
    end

    task automatic finish_test;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    task automatic check_byte(input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: expected %02h got %02h", $time, exp, got);
        end
    endtask : check_byte

    task automatic check_bit(input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: expected %01h got %01h", $time, exp, got);
        end
    endtask : check_bit

    task automatic step;
        @(posedge clk);
        #2;
    endtask : step

    task automatic pulse(input int which);
        step();
        prog_init_ack = (which == 0);
        prog_reject = (which == 1);
        prog_stack_status = (which == 2);
        step();
        {prog_init_ack, prog_reject, prog_stack_status} = 3'b000;
    endtask : pulse

    // ==========================================================
    // One selection; exp_st bit 8 skips status, exp_irq 2 skips request
    task automatic do_sel(input logic [7:0] a, input logic [7:0] c, input logic bad,
                          input logic exp_hit, input logic [8:0] exp_st, input int exp_irq,
                          input logic exp_emu);
        logic hit;
        logic [7:0] echo, st;
        int n;
        chan_u.sel(a, c, bad, hit, echo, st);
        check_bit(exp_hit, hit);
        if (exp_hit) begin
            check_byte(a, echo);
            if (!exp_st[8]) check_byte(exp_st[7:0], st);
        end
        n = 0;
        while (init_l3_req !== 1'b1 && n < 12) begin
            step();
            n++;
        end
        if (exp_irq != 2) check_bit(exp_irq[0], init_l3_req);
        if (exp_irq == 1) begin
            check_byte(a, isel_reg.dev_addr);
            check_byte(c, isel_reg.command);
            check_bit(1'b1, init_cause.selection);
            check_bit(exp_emu, init_cause.emulated_hit);
        end
        if (exp_irq == 3) check_bit(1'b1, init_cause.bus_out_check);
        pulse(0);
        check_bit(1'b0, init_l3_req);
    endtask : do_sel

    // ==========================================================
    // Main sequence
    initial begin
        {nrst, dual_intf, intf_b_active, hard_stop, boot_load} = 5'b00000;
        {emulated_subchannel_mode, prog_init_ack, prog_reject, prog_stack_status} = 4'b0000;
        intf_enable = 1'b1;
        prog_native_status = 8'h00;
        nat_a = 8'h5C;
        nat_b = 8'hA7;
        emu_lo = 8'h20;
        emu_hi = 8'h2B;
        repeat (8) @(posedge clk);
        check_bit(1'b0, init_l3_req);
        check_byte(8'h00, {2'b00, tags_in});
        #2 nrst = 1'b1;
        repeat (4) step();
        check_bit(1'b1, lamp);
        $display("test reset done");
        foreach (cmds[i]) do_sel(8'h5C, cmds[i], 1'b0, 1'b1, 9'h000, 1, 1'b0);
        do_sel(8'h5D, 8'h01, 1'b0, 1'b0, 9'h100, 0, 1'b0);
        check_bit(1'b1, native_subchannel_mode);
        $display("test native done");
        emulated_subchannel_mode = 1'b1;
        step();
        check_bit(1'b0, native_subchannel_mode);
        do_sel(8'h20, 8'h01, 1'b0, 1'b1, 9'h000, 1, 1'b1);
        do_sel(8'h2B, 8'h01, 1'b0, 1'b1, 9'h000, 1, 1'b1);
        do_sel(8'h1F, 8'h01, 1'b0, 1'b0, 9'h100, 0, 1'b0);
        do_sel(8'h2C, 8'h01, 1'b0, 1'b0, 9'h100, 0, 1'b0);
        do_sel(8'h24, cais_pkg::CMD_TEST_IO, 1'b0, 1'b1, 9'h100, 0, 1'b0);
        boot_load = 1'b1;
        step();
        check_bit(1'b1, native_subchannel_mode);
        do_sel(8'h5C, 8'h01, 1'b0, 1'b1, 9'h000, 1, 1'b0);
        {boot_load, emulated_subchannel_mode} = 2'b00;
        $display("test emulated done");
        {dual_intf, intf_b_active} = 2'b11;
        do_sel(8'hA7, 8'h01, 1'b0, 1'b1, 9'h000, 1, 1'b0);
        do_sel(8'h5C, 8'h01, 1'b0, 1'b0, 9'h100, 0, 1'b0);
        emulated_subchannel_mode = 1'b1;
        do_sel(8'h24, 8'h01, 1'b0, 1'b1, 9'h000, 1, 1'b1);
        {dual_intf, intf_b_active, emulated_subchannel_mode} = 3'b000;
        $display("test dual done");
        hard_stop = 1'b1;
        do_sel(8'h5C, 8'h01, 1'b0, 1'b0, 9'h100, 0, 1'b0);
        check_bit(1'b1, lamp);
        hard_stop = 1'b0;
        intf_enable = 1'b0;
        do_sel(8'h5C, 8'h01, 1'b0, 1'b0, 9'h100, 0, 1'b0);
        check_bit(1'b0, lamp);
        intf_enable = 1'b1;
        $display("test gating done");
        do_sel(8'h5C, 8'h01, 1'b1, 1'b1, 9'h002, 3, 1'b0);
        do_sel(8'h5C, cais_pkg::CMD_NOOP, 1'b0, 1'b1, 9'h00C, 0, 1'b0);
        pulse(1);
        check_bit(1'b1, tags_in.request);
        do_sel(8'h5C, 8'h01, 1'b0, 1'b1, {1'b0, cais_pkg::ST_CHAN_END | cais_pkg::ST_UNIT_FINISHED
            | cais_pkg::ST_ERROR}, 0, 1'b0);
        prog_native_status = 8'h5A;
        pulse(2);
        do_sel(8'h5C, 8'h01, 1'b0, 1'b1, 9'h05A, 0, 1'b0);
        do_sel(8'h5C, 8'h01, 1'b0, 1'b1, 9'h000, 1, 1'b0);
        check_bit(1'b0, data_l3_req);
        $display("test status done");
        finish_test();
    end
endmodule : tb_channel_adapter_initial_selection
`default_nettype wire
